// File: design/gpx_defines.vh
// register indices, reset values and field positions of the port block
`ifndef GPX_DEFINES_VH
`define GPX_DEFINES_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define GPX_IDX_G1_DATA     6'h1c
`define GPX_IDX_G1_DIR      6'h1e
`define GPX_IDX_G1_FUNC     6'h1f
`define GPX_IDX_G2_DATA     6'h20
`define GPX_IDX_G2_DIR      6'h22
`define GPX_IDX_G2_FUNC     6'h23
`define GPX_IDX_G3_DATA     6'h24
`define GPX_IDX_G3_DIR      6'h26
`define GPX_IDX_G3_FUNC     6'h27
`define GPX_IDX_OD_ENABLE   6'h28
`define GPX_IDX_IRQ0_SENSE  6'h29

// ****************************************************************
// reset values
// ****************************************************************
`define GPX_RST_G1_LATCH    6'h3f
`define GPX_RST_G1_DIR      6'h00
`define GPX_RST_G1_FUNC     6'h00
`define GPX_RST_G2_LATCH    8'hff
`define GPX_RST_G2_DIR      8'h00
`define GPX_RST_G2_FUNC     8'h00
`define GPX_RST_G3_LATCH    8'hff
`define GPX_RST_G3_DIR      8'hc0
`define GPX_RST_G3_FUNC     8'h00
`define GPX_RST_OD_ENABLE   8'h00
`define GPX_RST_IRQ0_SENSE  2'h0

// ****************************************************************
// field positions
// ****************************************************************
`define GPX_G1_TMR8A_IN_BIT   0
`define GPX_G1_TMR8A_OUT_BIT  1
`define GPX_G1_TMR8B_IN_BIT   3
`define GPX_G1_TMR8B_OUT_BIT  4
`define GPX_G1_IRQ0_BIT       5
`define GPX_G1_FUNC_MASK      6'h32
`define GPX_G3_FUNC_MASK      8'hed
`define GPX_OD_TXD0_BIT       3
`define GPX_OD_TXD1_BIT       4
`define GPX_SENSE_EDGE_BIT    0
`define GPX_SENSE_LEVEL_BIT   1
`define GPX_HTRANS_NONSEQ_BIT 1

`endif

// File: design/gpx_ports.v
// general-purpose port block with timer, interrupt and serial pin muxing
`timescale 1ns/1ps
`include "gpx_defines.vh"

// Overview of operation
// - six-pin port, inputs, latches one after reset
// - reset clears six-pin direction and function
// - direction and function registers are write-only
// - data read gives pins, write loads latch
// - pin five function input feeds interrupt zero
// - sense bits pick rising, falling, high, low
// - pin one function output drives timer pair a
// - pin four function output drives timer pair b
// - pins zero, three always feed timer inputs
// - eight-pin port, inputs, latches one after reset
// - reset clears eight-pin direction and function
// - function inputs feed captures and interrupts five-eight
// - function outputs drive sixteen-bit timer outputs
// - third port pins zero to five reset input, serial roles
// - oscillator pins open-drain, reset latch, direction one
// - transmit pins open-drain via enable register
module gpx_ports (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hclken,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire [31:0] hrdata,
    output wire        hresp,
    input  wire [5:0]  g1_pin_in,
    output wire [5:0]  g1_pin_out,
    output wire [5:0]  g1_pin_oe,
    input  wire [7:0]  g2_pin_in,
    output wire [7:0]  g2_pin_out,
    output wire [7:0]  g2_pin_oe,
    input  wire [7:0]  g3_pin_in,
    output wire [7:0]  g3_pin_out,
    output wire [7:0]  g3_pin_oe,
    input  wire        timer8_pair_a_out,
    input  wire        timer8_pair_b_out,
    output wire        timer8_pair_a_in,
    output wire        timer8_pair_b_in,
    input  wire        timer16_a_out_first,
    input  wire        timer16_a_out_second,
    input  wire        timer16_b_out_first,
    input  wire        timer16_b_out_second,
    output wire [1:0]  timer16_a_capture,
    output wire [1:0]  timer16_b_capture,
    output wire        ext_irq_zero,
    output wire        ext_irq_five,
    output wire        ext_irq_six,
    output wire        ext_irq_seven,
    output wire        ext_irq_eight,
    input  wire        serial0_txd,
    input  wire        serial1_txd,
    input  wire        serial0_clk_out,
    input  wire        serial1_clk_out,
    output wire        serial0_rxd,
    output wire        serial1_rxd,
    output wire        serial0_clk_in,
    output wire        serial1_clk_in,
    output wire        slow_osc_in,
    output wire        slow_osc_out,
    output wire        slow_osc_select
);

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // both helpers take one function bit and one direction bit
    // pin selected for an alternate input role: function one, input
    function alt_in;
        input f;
        input d;
        begin
            alt_in = f & ~d;
        end
    endfunction

    // pin selected for an alternate output role: function one, output
    function alt_out;
        input f;
        input d;
        begin
            alt_out = f & d;
        end
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    // latches reset to one so a pin turned output idles high
    // direction and function reset to zero: plain inputs
    // the oscillator pins reset as outputs, released high
    reg  [5:0]  g1_latch_reg;
    reg  [5:0]  g1_dir_reg;
    reg  [5:0]  g1_func_reg;
    reg  [7:0]  g2_latch_reg;
    reg  [7:0]  g2_dir_reg;
    reg  [7:0]  g2_func_reg;
    reg  [7:0]  g3_latch_reg;
    reg  [7:0]  g3_dir_reg;
    reg  [7:0]  g3_func_reg;
    reg  [7:0]  od_enable_reg;
    reg  [1:0]  irq0_sense_reg;
    reg         wr_pend_reg;
    reg  [5:0]  wr_idx_reg;
    reg  [31:0] rdata_reg;
    reg         irq0_prev_reg;
    reg         irq0_out_reg;
    reg  [31:0] rdata_next;
    reg         irq0_next;

    wire        addr_take;
    wire [5:0]  addr_idx;
    wire [7:0]  wdata;
    wire        irq0_sel;
    wire        irq0_pin;

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************

    // single-word transfers only; hsize is not decoded
    // only the low byte of hwdata reaches a register
    // write data is taken one edge after the address
    // read data is captured at the address edge
    // hrdata then stands until the next read address
    // a low clock enable stalls both bus phases
    // write-only registers read back as zero
    // unmapped indices read zero, writes are dropped
    // zero wait states; a frozen clock enable stalls the bus
    assign hreadyout = hclken;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;
    assign addr_idx  = haddr[7:2];
    assign wdata     = hwdata[7:0];
    assign addr_take = hsel & hready & htrans[`GPX_HTRANS_NONSEQ_BIT];

    // read mux, sampled at the end of the address phase
    // write-only registers read zero
    always @* begin
        rdata_next = 32'h0000_0000;
        case (addr_idx)
            `GPX_IDX_G1_DATA:    rdata_next = {24'h00_0000, 2'h0, g1_pin_in};
            `GPX_IDX_G2_DATA:    rdata_next = {24'h00_0000, g2_pin_in};
            `GPX_IDX_G3_DATA:    rdata_next = {24'h00_0000, g3_pin_in};
            `GPX_IDX_OD_ENABLE:  rdata_next = {24'h00_0000, od_enable_reg};
            `GPX_IDX_IRQ0_SENSE: rdata_next = {24'h00_0000, 6'h00, irq0_sense_reg};
            default:             rdata_next = 32'h0000_0000;
        endcase
    end

    // bus phase tracking and read data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 6'h00;
            rdata_reg   <= 32'h0000_0000;
        end else if (hclken) begin
            if (hready) begin
                wr_pend_reg <= addr_take & hwrite;
                wr_idx_reg  <= addr_idx;
            end
            if (addr_take & ~hwrite) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // writes land at the end of the data phase; the
    // function masks keep bits without a role at zero
    // register writes in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            g1_latch_reg   <= `GPX_RST_G1_LATCH;
            g1_dir_reg     <= `GPX_RST_G1_DIR;
            g1_func_reg    <= `GPX_RST_G1_FUNC;
            g2_latch_reg   <= `GPX_RST_G2_LATCH;
            g2_dir_reg     <= `GPX_RST_G2_DIR;
            g2_func_reg    <= `GPX_RST_G2_FUNC;
            g3_latch_reg   <= `GPX_RST_G3_LATCH;
            g3_dir_reg     <= `GPX_RST_G3_DIR;
            g3_func_reg    <= `GPX_RST_G3_FUNC;
            od_enable_reg  <= `GPX_RST_OD_ENABLE;
            irq0_sense_reg <= `GPX_RST_IRQ0_SENSE;
        end else if (hclken && wr_pend_reg) begin
            case (wr_idx_reg)
                `GPX_IDX_G1_DATA:    g1_latch_reg   <= wdata[5:0];
                `GPX_IDX_G1_DIR:     g1_dir_reg     <= wdata[5:0];
                `GPX_IDX_G1_FUNC:    g1_func_reg    <= wdata[5:0] & `GPX_G1_FUNC_MASK;
                `GPX_IDX_G2_DATA:    g2_latch_reg   <= wdata;
                `GPX_IDX_G2_DIR:     g2_dir_reg     <= wdata;
                `GPX_IDX_G2_FUNC:    g2_func_reg    <= wdata;
                `GPX_IDX_G3_DATA:    g3_latch_reg   <= wdata;
                `GPX_IDX_G3_DIR:     g3_dir_reg     <= wdata;
                `GPX_IDX_G3_FUNC:    g3_func_reg    <= wdata & `GPX_G3_FUNC_MASK;
                `GPX_IDX_OD_ENABLE:  od_enable_reg  <= wdata;
                `GPX_IDX_IRQ0_SENSE: irq0_sense_reg <= wdata[1:0];
                default:             g1_latch_reg   <= g1_latch_reg;
            endcase
        end
    end

    // ****************************************************************
    // six-pin port
    // ****************************************************************

    // pins 0 and 3 have no function bit of their own
    // pin 5 has no output role; it only feeds irq zero
    // a reserved function and direction pair keeps the
    // pin on its latch, so stray setups stay harmless
    // direction and function writes act at once
    // software must write whole values, not patch bits
    // direction bit drives the pin
    assign g1_pin_oe = g1_dir_reg;

    // timer pair a replaces latch on pin one
    // timer pair b replaces latch on pin four
    // reserved combinations fall back to the latch
    assign g1_pin_out = {
        g1_latch_reg[5],
        alt_out(g1_func_reg[4], g1_dir_reg[4]) ? timer8_pair_b_out : g1_latch_reg[4],
        g1_latch_reg[3:2],
        alt_out(g1_func_reg[1], g1_dir_reg[1]) ? timer8_pair_a_out : g1_latch_reg[1],
        g1_latch_reg[0]
    };

    // the timer sees the pin whatever the direction, so
    // an output pin also loops back into its timer
    // timer inputs always see the pins
    assign timer8_pair_a_in = g1_pin_in[`GPX_G1_TMR8A_IN_BIT];
    assign timer8_pair_b_in = g1_pin_in[`GPX_G1_TMR8B_IN_BIT];

    // ****************************************************************
    // interrupt zero sense
    // ****************************************************************

    // the pin is sampled at every enabled edge
    // edge modes give a one-cycle request pulse
    // level modes follow the pin one cycle late
    // the history flop runs even while unselected,
    // so selecting the pin never fakes an edge
    // the request drops one edge after the pin
    // leaves its interrupt role
    // pin five as input with function one
    assign irq0_sel = alt_in(g1_func_reg[5], g1_dir_reg[5]);
    assign irq0_pin = g1_pin_in[`GPX_G1_IRQ0_BIT];

    // edge or level sense from the two select bits
    always @* begin
        irq0_next = 1'b0;
        case (irq0_sense_reg)
            2'b00:   irq0_next = irq0_pin & ~irq0_prev_reg;
            2'b01:   irq0_next = ~irq0_pin & irq0_prev_reg;
            2'b10:   irq0_next = irq0_pin;
            2'b11:   irq0_next = ~irq0_pin;
            default: irq0_next = 1'b0;
        endcase
    end

    // pin history and registered request
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq0_prev_reg <= 1'b0;
            irq0_out_reg  <= 1'b0;
        end else if (hclken) begin
            irq0_prev_reg <= irq0_pin;
            irq0_out_reg  <= irq0_sel & irq0_next;
        end
    end

    assign ext_irq_zero = irq0_out_reg;

    // ****************************************************************
    // eight-pin port
    // ****************************************************************
    // pins 0, 1, 4, 5 are capture and interrupt inputs
    // pins 2, 3, 6, 7 carry sixteen-bit timer outputs
    // captures read zero when not selected, so a
    // timer never sees a pin that software gave away
    // interrupts five to eight share the capture paths
    assign g2_pin_oe = g2_dir_reg;

    // sixteen-bit timer outputs on pins 2, 3, 6, 7
    assign g2_pin_out = {
        alt_out(g2_func_reg[7], g2_dir_reg[7]) ? timer16_b_out_second : g2_latch_reg[7],
        alt_out(g2_func_reg[6], g2_dir_reg[6]) ? timer16_b_out_first  : g2_latch_reg[6],
        g2_latch_reg[5:4],
        alt_out(g2_func_reg[3], g2_dir_reg[3]) ? timer16_a_out_second : g2_latch_reg[3],
        alt_out(g2_func_reg[2], g2_dir_reg[2]) ? timer16_a_out_first  : g2_latch_reg[2],
        g2_latch_reg[1:0]
    };

    // all four are plain levels; edge detection sits
    // in the timer or the interrupt controller
    // capture inputs and interrupts five to eight
    assign timer16_a_capture[0] = g2_pin_in[0] & alt_in(g2_func_reg[0], g2_dir_reg[0]);
    assign timer16_a_capture[1] = g2_pin_in[1] & alt_in(g2_func_reg[1], g2_dir_reg[1]);
    assign timer16_b_capture[0] = g2_pin_in[4] & alt_in(g2_func_reg[4], g2_dir_reg[4]);
    assign timer16_b_capture[1] = g2_pin_in[5] & alt_in(g2_func_reg[5], g2_dir_reg[5]);
    assign ext_irq_five  = timer16_a_capture[0];
    assign ext_irq_six   = timer16_a_capture[1];
    assign ext_irq_seven = timer16_b_capture[0];
    assign ext_irq_eight = timer16_b_capture[1];

    // ****************************************************************
    // third port: serial and oscillator pins
    // ****************************************************************
    // pins 1 and 4 are receive inputs, no function bit
    // pins 0 and 3 transmit, pins 2 and 5 serial clocks
    // pins 6 and 7 only pull low, never drive high,
    // so an oscillator on them is not fought after reset
    // transmit pins turn open-drain by the enable bits
    // an open-drain pin drives only while its value is low
    // per-pin open-drain flags and the value before them
    wire       txd0_od;
    wire       txd1_od;
    wire [7:0] g3_value;
    wire [7:0] g3_od;

    // serial output roles when function and output
    assign g3_value = {
        g3_latch_reg[7:6],
        alt_out(g3_func_reg[5], g3_dir_reg[5]) ? serial1_clk_out : g3_latch_reg[5],
        g3_latch_reg[4],
        alt_out(g3_func_reg[3], g3_dir_reg[3]) ? serial1_txd : g3_latch_reg[3],
        alt_out(g3_func_reg[2], g3_dir_reg[2]) ? serial0_clk_out : g3_latch_reg[2],
        g3_latch_reg[1],
        alt_out(g3_func_reg[0], g3_dir_reg[0]) ? serial0_txd : g3_latch_reg[0]
    };

    // transmit pins open-drain by enable register
    assign txd0_od = od_enable_reg[`GPX_OD_TXD0_BIT];
    assign txd1_od = od_enable_reg[`GPX_OD_TXD1_BIT];

    assign g3_od = {2'b11, 1'b0, 1'b0, txd1_od, 1'b0, 1'b0, txd0_od};

    // open-drain pins only pull low; others drive the value
    assign g3_pin_out = g3_value & ~g3_od;
    assign g3_pin_oe  = g3_dir_reg & (~g3_od | ~g3_value);

    // serial inputs always see their pins
    assign serial0_rxd    = g3_pin_in[1];
    assign serial1_rxd    = g3_pin_in[4];
    assign serial0_clk_in = g3_pin_in[2];
    assign serial1_clk_in = g3_pin_in[5];

    // the oscillator is outside this block; these
    // outputs only pass the pin levels and the role on
    // oscillator role when function bits are clear
    assign slow_osc_select = ~g3_func_reg[6] & ~g3_func_reg[7];
    assign slow_osc_in     = g3_pin_in[6];
    assign slow_osc_out    = g3_pin_in[7];

endmodule

// File: testbench/gpx_ports_chk.sv
// assertion checker for the port block bus and pin routing
`timescale 1ns/1ps
`include "gpx_defines.vh"

module gpx_ports_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire        hclken,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire [31:0] hrdata,
    input wire        hresp,
    input wire [5:0]  g1_pin_in,
    input wire [5:0]  g1_pin_oe,
    input wire [7:0]  g2_pin_in,
    input wire [7:0]  g3_pin_out,
    input wire        timer8_pair_a_in,
    input wire        timer8_pair_b_in,
    input wire [1:0]  timer16_a_capture,
    input wire [1:0]  timer16_b_capture,
    input wire        ext_irq_zero,
    input wire        ext_irq_five,
    input wire        ext_irq_eight
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // request taken at this edge
    wire take = hclken && hsel && hready && htrans[1];

    a_dir_write: assert property (
        take && hwrite && haddr[7:2] == `GPX_IDX_G1_DIR ##1 hclken
        |=> g1_pin_oe == $past(hwdata[5:0])) else $error("direction write lost");
    a_read_pins: assert property (
        take && !hwrite && haddr[7:2] == `GPX_IDX_G2_DATA
        |=> hrdata[7:0] == $past(g2_pin_in)) else $error("read not pin level");
    a_rdata_upper: assert property (
        hrdata[31:8] == 24'h0000_00) else $error("upper read bits set");
    a_bus_okay: assert property (
        !hresp && hreadyout == hclken) else $error("bus answer wrong");
    a_tmr8_feed: assert property (
        {timer8_pair_b_in, timer8_pair_a_in} == {g1_pin_in[3], g1_pin_in[0]})
        else $error("timer input not pin");
    a_irq_pair: assert property (
        {ext_irq_eight, ext_irq_five} == {timer16_b_capture[1], timer16_a_capture[0]})
        else $error("irq and capture differ");
    a_cap_gate: assert property (
        (timer16_a_capture & ~g2_pin_in[1:0]) == 2'h0) else $error("capture without pin");
    a_irq0_input: assert property (
        ext_irq_zero |-> !$past(g1_pin_oe[5])) else $error("irq zero from output pin");
    a_osc_drain: assert property (
        g3_pin_out[7:6] == 2'h0) else $error("osc pin drives high");

    c_write: cover property (take && hwrite);
    c_wait: cover property (hsel && !hclken);
    c_irq0: cover property (ext_irq_zero);
endmodule

bind gpx_ports gpx_ports_chk i_chk (.hclk, .hresetn, .hclken, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .g1_pin_in, .g1_pin_oe,
    .g2_pin_in, .g3_pin_out, .timer8_pair_a_in, .timer8_pair_b_in, .timer16_a_capture,
    .timer16_b_capture, .ext_irq_zero, .ext_irq_five, .ext_irq_eight);

// File: testbench/gpx_board.sv
// board model that resolves each port pin from block drive and board level
`timescale 1ns/1ps

module gpx_board #(
    parameter W = 8
) (
    input  wire [W-1:0] oe,
    input  wire [W-1:0] out,
    input  wire [W-1:0] ext,
    output wire [W-1:0] pin
);
    // a driven pin shows the block value, else the board level
    assign pin = (oe & out) | (~oe & ext);
endmodule

// File: testbench/gpx_ports_bench.sv
// self-checking bench for the port block
`timescale 1ns/1ps
`include "gpx_defines.vh"

module gpx_ports_bench;
    reg         hclk;
    reg         hresetn;
    reg         hclken = 1'b1;
    reg         hsel;
    reg         hwrite;
    reg  [7:0]  haddr;
    reg  [1:0]  htrans;
    reg  [31:0] hwdata;
    reg  [5:0]  x1;
    reg  [7:0]  x2;
    reg  [7:0]  x3;
    reg  [9:0]  tin;
    reg  [31:0] d;
    reg  [31:0] rv;
    wire        hreadyout;
    wire        hresp;
    wire [31:0] hrdata;
    wire [5:0]  p1i, p1o, p1e;
    wire [7:0]  p2i, p2o, p2e, p3i, p3o, p3e;
    wire [1:0]  ca, cb;
    wire        t8a, t8b, q0, q5, q6, q7, q8, s0r;
    wire        s1r, s0k, s1k, osi, oso, osl;
    integer     mismatches, n_tests, seed, cyc, r, f, m, k, jit;
    integer     mreg [0:63];

    gpx_ports i_gpx_ports (.hclk, .hresetn, .hclken, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .g1_pin_in(p1i), .g1_pin_out(p1o), .g1_pin_oe(p1e), .g2_pin_in(p2i),
        .g2_pin_out(p2o), .g2_pin_oe(p2e), .g3_pin_in(p3i), .g3_pin_out(p3o),
        .g3_pin_oe(p3e), .timer8_pair_a_out(tin[0]), .timer8_pair_b_out(tin[1]),
        .timer8_pair_a_in(t8a), .timer8_pair_b_in(t8b), .timer16_a_out_first(tin[2]),
        .timer16_a_out_second(tin[3]), .timer16_b_out_first(tin[4]),
        .timer16_b_out_second(tin[5]), .timer16_a_capture(ca), .timer16_b_capture(cb),
        .ext_irq_zero(q0), .ext_irq_five(q5), .ext_irq_six(q6), .ext_irq_seven(q7),
        .ext_irq_eight(q8), .serial0_txd(tin[6]), .serial1_txd(tin[7]),
        .serial0_clk_out(tin[8]), .serial1_clk_out(tin[9]), .serial0_rxd(s0r),
        .serial1_rxd(s1r), .serial0_clk_in(s0k), .serial1_clk_in(s1k), .slow_osc_in(osi),
        .slow_osc_out(oso), .slow_osc_select(osl));
    gpx_board #(.W(6)) i_board1 (.oe(p1e), .out(p1o), .ext(x1), .pin(p1i));
    gpx_board #(.W(8)) i_board2 (.oe(p2e), .out(p2o), .ext(x2), .pin(p2i));
    gpx_board #(.W(8)) i_board3 (.oe(p3e), .out(p3o), .ext(x3), .pin(p3i));

    // ****************************************************************
    // clock, wait states and hang guard
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        hclken <= !jit || ($random(seed) & 3) != 0;
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            conclude;
        end
    end

    task chk(input string s, input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one single bus transfer, master side
    task xf(input [5:0] i, input w, input [7:0] v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {i, 2'b00};
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0000_00, v};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rv = hrdata;
        if (w) mreg[i] = v;
    endtask
    task wr(input [5:0] i, input [7:0] v);
        xf(i, 1'b1, v);
    endtask
    task rd(input [5:0] i, input [7:0] e, input string s);
        xf(i, 1'b0, 8'h00);
        chk(s, rv, {24'h0000_00, e});
    endtask
    // counts irq zero high cycles over a window, then checks its level
    task win(output integer c, input e);
        c = 0;
        repeat (6) begin
            @(negedge hclk);
            c = c + q0;
        end
        chk("irq0 level", q0, e);
        @(posedge hclk);
    endtask
    function [7:0] lv(input integer di, input integer la, input [7:0] e);
        lv = (di & la) | (~di & e);
    endfunction

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, x1, x3, tin} = 0;
        {mismatches, n_tests, cyc, jit} = 0;
        seed = 2;
        x2 = 8'hff;
        for (k = 0; k < 64; k = k + 1) mreg[k] = 0;
        mreg[`GPX_IDX_G1_DATA] = 255;
        mreg[`GPX_IDX_G2_DATA] = 255;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("oe reset", {p3e, p2e, p1e}, 0);
        chk("capture reset", {cb, ca}, 0);
        @(posedge hclk);
        wr(`GPX_IDX_G1_DIR, 8'h3f);
        wr(`GPX_IDX_G2_DIR, 8'hff);
        @(negedge hclk);
        chk("latch1 reset", p1o, mreg[`GPX_IDX_G1_DATA] & 63);
        chk("latch2 reset", p2o, mreg[`GPX_IDX_G2_DATA]);
        $display("test reset done");
        @(posedge hclk);
        jit = 1;
        repeat (8) begin
            d = $random(seed);
            wr(`GPX_IDX_G1_DIR, d[7:0]);
            wr(`GPX_IDX_G2_DIR, d[15:8]);
            wr(`GPX_IDX_G1_DATA, d[23:16]);
            wr(`GPX_IDX_G2_DATA, d[31:24]);
            x1 <= $random(seed);
            x2 <= $random(seed);
            @(posedge hclk);
            d = lv(mreg[`GPX_IDX_G1_DIR], mreg[`GPX_IDX_G1_DATA], x1) & 63;
            rd(`GPX_IDX_G1_DATA, d[7:0], "port1 read");
            chk("timer8 feed", {t8b, t8a}, {d[3], d[0]});
            chk("oe1", p1e, mreg[`GPX_IDX_G1_DIR] & 63);
            rd(`GPX_IDX_G2_DATA, lv(mreg[`GPX_IDX_G2_DIR], mreg[`GPX_IDX_G2_DATA], x2),
                "port2 read");
        end
        jit = 0;
        $display("test direction done");
        wr(`GPX_IDX_G1_DIR, 8'h3f);
        wr(`GPX_IDX_G1_FUNC, 8'h3f);
        wr(`GPX_IDX_G1_DATA, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            tin <= k;
            @(negedge hclk);
            chk("timer8 out", p1o, {k[1], 2'b00, k[0], 1'b0});
            @(posedge hclk);
        end
        wr(`GPX_IDX_G2_DIR, 8'hcc);
        wr(`GPX_IDX_G2_FUNC, 8'hff);
        wr(`GPX_IDX_G2_DATA, 8'h00);
        repeat (4) begin
            d = $random(seed);
            tin <= d[9:0];
            x2 <= d[23:16];
            @(negedge hclk);
            chk("timer16 out", p2o, {d[5:4], 2'b00, d[3:2], 2'b00});
            chk("capture", {cb, ca}, {d[21:20], d[17:16]});
            chk("irq5to8", {q8, q7, q6, q5}, {d[21:20], d[17:16]});
            @(posedge hclk);
        end
        $display("test timers done");
        wr(`GPX_IDX_G1_DIR, 8'h00);
        wr(`GPX_IDX_G1_FUNC, 8'h20);
        for (m = 0; m < 4; m = m + 1) begin
            x1 <= 6'h00;
            wr(`GPX_IDX_IRQ0_SENSE, m);
            repeat (4) @(posedge hclk);
            x1 <= 6'h20;
            win(r, m == 2);
            x1 <= 6'h00;
            win(f, m == 3);
            if (m < 2) chk("irq0 edge", 2 * r + f, 2 - m);
        end
        wr(`GPX_IDX_G1_FUNC, 8'h00);
        @(posedge hclk);
        @(negedge hclk);
        chk("irq0 off", q0, 0);
        $display("test irq0 done");
        @(posedge hclk);
        x3 <= 8'h02;
        wr(`GPX_IDX_G3_DATA, 8'h00);
        @(negedge hclk);
        chk("osc drain", p3e, 8'hc0);
        chk("rxd feed", s0r, 1);
        @(posedge hclk);
        wr(`GPX_IDX_OD_ENABLE, 8'h18);
        wr(`GPX_IDX_G3_DIR, 8'hc9);
        wr(`GPX_IDX_G3_DATA, 8'h01);
        @(negedge hclk);
        chk("txd drain", {p3e, p3o & p3e}, 16'hc800);
        @(posedge hclk);
        wr(`GPX_IDX_OD_ENABLE, 8'h00);
        wr(`GPX_IDX_G3_DIR, 8'h2d);
        wr(`GPX_IDX_G3_FUNC, 8'hff);
        d = $random(seed);
        tin <= d[9:0];
        x3 <= d[23:16];
        @(negedge hclk);
        chk("serial out", p3o, {2'b00, d[9], 1'b0, d[7], d[8], 1'b0, d[6]});
        chk("serial oe", p3e, 8'h2d);
        chk("serial in", {s1r, s0r, s0k, s1k}, {d[20], d[17], d[8], d[9]});
        chk("osc role", {osl, oso, osi}, {1'b0, d[23:22]});
        @(posedge hclk);
        wr(6'h3f, 8'hff);
        rd(6'h3f, 8'h00, "unmapped");
        rd(`GPX_IDX_G1_FUNC, 8'h00, "write only");
        $display("test port3 done");
        conclude;
    end
endmodule
